// File: cdec_event_ctrl.sv
// cdec_event_ctrl: debug event, halt and monitor control of a core.
// assumes core signals share ref_clk_i; request pins are asynchronous
// Function
// RL1: halt mode events stop and isolate core
// RL2: monitor mode raises prefetch or data abort
// RL3: four entry sources incl scanned request
// RL4: two comparators, control, status, comms channel
// RL5: each unit breakpoint or watchpoint
// RL6: match when all programmed fields equal
// RL7: per bit masks exclude bits
// RL8: halt mode matches may use data
// RL9: registers programmed serially by host
// RL10: inject instructions while in debug state
// RL11: enable low blocks external requests
// RL12: enable low holds acknowledge low
// RL13: tying enable low disables debug forever; here comparator matches and the scanned request still halt the core
// RL14: acknowledge shows core in debug state
// RL15: system may drive external requests
// RL16: enable ANDed before combining requests
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module cdec_event_ctrl (
    input logic ref_clk_i,
    input logic rstn_i,
    input logic [7:0] reg_addr_i,
    input logic [31:0] reg_wdata_i,
    input logic reg_write_i,
    input logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    input logic scan_clk_i,
    input logic scan_din_i,
    input logic scan_update_i,
    output logic scan_dout_o,
    input logic debug_global_enable_i,
    input logic ext_breakpoint_request_i,
    input logic ext_watchpoint_request_i,
    input logic ext_debug_request_i,
    input cdec_pkg::cdec_bus_type fetch_i,
    input cdec_pkg::cdec_bus_type data_i,
    input logic core_stopped_i,
    input logic comms_read_i,
    input logic comms_write_i,
    input logic [31:0] comms_wdata_i,
    output logic debug_state_ack_o,
    output logic core_halt_o,
    output logic prefetch_abort_o,
    output logic data_abort_o,
    output logic inject_valid_o,
    output logic [31:0] inject_instr_o,
    output logic [31:0] comms_rdata_o,
    output logic comms_rx_full_o
);
    typedef struct packed {
        logic [cdec_pkg::SYNC_W-1:0] sync_a;
        logic [cdec_pkg::SYNC_W-1:0] sync_b;
        cdec_pkg::cdec_dbg_state_type dbg;
        logic halt;
        logic ack;
        logic pabort;
        logic dabort;
        logic inj_valid;
        logic [31:0] inj_instr;
        logic monitor;
        logic dly_req;
        logic brk_hit;
        logic wpt_hit;
        logic ext_hit;
        logic [31:0] to_core;
        logic rx_full;
        logic [31:0] from_core;
        logic tx_full;
        cdec_pkg::cdec_unit_type [cdec_pkg::NUM_UNITS-1:0] unit;
        cdec_pkg::cdec_acc_type pend;
        logic [31:0] rdata;
        logic scan_rsp;
        logic [31:0] scan_data;
    } cdec_ctrl_state_type;

    cdec_ctrl_state_type st_reg;
    cdec_ctrl_state_type st_next;
    cdec_pkg::cdec_acc_type scan_acc;
    cdec_pkg::cdec_acc_type acc;
    logic [cdec_pkg::NUM_UNITS-1:0] unit_match;
    logic [cdec_pkg::NUM_UNITS-1:0] unit_kind;
    logic [2:0] ext_gated;
    logic en;
    logic brk_any;
    logic wpt_any;
    logic req_any;
    logic halt_evt;
    logic in_run;
    logic use_bus;
    logic [31:0] rd;
    logic [2:0] uidx;
    logic [4:0] uoff;
    logic resume_req;

    // serial host access path
    cdec_scan_chain u_scan (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .scan_clk_i(scan_clk_i),
        .scan_din_i(scan_din_i),
        .scan_update_i(scan_update_i),
        .rsp_valid_i(st_reg.scan_rsp),
        .rsp_data_i(st_reg.scan_data),
        .acc_o(scan_acc),
        .scan_dout_o(scan_dout_o)
    );

    // RL4 two comparator units
    for (genvar g = 0; g < cdec_pkg::NUM_UNITS; g++)
    begin : g_unit
        cdec_match_unit u_match (
            .cfg_i(st_reg.unit[g]),
            .fetch_i(fetch_i),
            .data_i(data_i),
            .match_o(unit_match[g])
        );
        assign unit_kind[g] = st_reg.unit[g].kind;
    end

    // RL11 gate external requests
    assign en = st_reg.sync_b[cdec_pkg::SYNC_EN];
    // RL16 AND before combining
    assign ext_gated = st_reg.sync_b[2:0] & {3{en}};
    // RL3 combine entry sources
    assign brk_any = (|(unit_match & unit_kind))
        | ext_gated[cdec_pkg::SYNC_BRK];
    assign wpt_any = (|(unit_match & ~unit_kind))
        | ext_gated[cdec_pkg::SYNC_WPT];
    assign req_any = ext_gated[cdec_pkg::SYNC_REQ] | st_reg.dly_req;
    assign halt_evt = req_any | (~st_reg.monitor & (brk_any | wpt_any));
    assign in_run = (st_reg.dbg == cdec_pkg::ST_RUN);
    assign use_bus = reg_write_i | reg_read_i;

    // register access, event handling and debug state sequencing
    always_comb
    begin
        st_next = st_reg;
        acc = use_bus ? {1'b1, reg_write_i, reg_addr_i, reg_wdata_i}
            : st_reg.pend;
        rd = cdec_pkg::WORD_RST;
        resume_req = 1'b0;
        uidx = acc.addr[cdec_pkg::ADDR_W-1:cdec_pkg::UNIT_IDX_LSB];
        uoff = acc.addr[cdec_pkg::UNIT_IDX_LSB-1:0];
        // request and enable pins pass two flops
        st_next.sync_a = {debug_global_enable_i, ext_debug_request_i,
            ext_watchpoint_request_i, ext_breakpoint_request_i};
        st_next.sync_b = st_reg.sync_a;
        st_next.inj_valid = 1'b0;
        st_next.scan_rsp = 1'b0;
        // scan access waits while the plain port is busy
        if (!use_bus)
        begin
            st_next.pend.valid = 1'b0;
        end
        if (scan_acc.valid)
        begin
            st_next.pend = scan_acc;
        end
        // read mux
        case (acc.addr)
            cdec_pkg::REG_CTRL:
                rd[cdec_pkg::CTRL_MON_BIT] = st_reg.monitor;
            cdec_pkg::REG_STAT:
            begin
                rd[cdec_pkg::STAT_DEBUG_BIT] = (st_reg.dbg == cdec_pkg::ST_HALT);
                rd[cdec_pkg::STAT_BRK_BIT] = st_reg.brk_hit;
                rd[cdec_pkg::STAT_WPT_BIT] = st_reg.wpt_hit;
                rd[cdec_pkg::STAT_EXT_BIT] = st_reg.ext_hit;
                rd[cdec_pkg::STAT_EN_BIT] = en;
                rd[cdec_pkg::STAT_RXF_BIT] = st_reg.rx_full;
                rd[cdec_pkg::STAT_TXF_BIT] = st_reg.tx_full;
            end
            cdec_pkg::REG_DLY:
                rd[cdec_pkg::DLY_REQ_BIT] = st_reg.dly_req;
            cdec_pkg::REG_INJ:
                rd = st_reg.inj_instr;
            cdec_pkg::REG_COMM_TO:
                rd = st_reg.to_core;
            cdec_pkg::REG_COMM_FROM:
                rd = st_reg.from_core;
            default:
            begin
                for (int i = 0; i < cdec_pkg::NUM_UNITS; i++)
                begin
                    if (uidx == cdec_pkg::UNIT_IDX_BASE + 3'(i))
                    begin
                        case (uoff)
                            cdec_pkg::UNIT_AVAL: rd = st_reg.unit[i].addr_val;
                            cdec_pkg::UNIT_AMSK: rd = st_reg.unit[i].addr_msk;
                            cdec_pkg::UNIT_DVAL: rd = st_reg.unit[i].data_val;
                            cdec_pkg::UNIT_DMSK: rd = st_reg.unit[i].data_msk;
                            cdec_pkg::UNIT_CTL:
                                rd = {22'h0, st_reg.unit[i].kind,
                                    st_reg.unit[i].enable,
                                    st_reg.unit[i].ctrl_msk,
                                    st_reg.unit[i].ctrl_val};
                            default: rd = cdec_pkg::WORD_RST;
                        endcase
                    end
                end
            end
        endcase
        st_next.rdata = reg_read_i ? rd : cdec_pkg::WORD_RST;
        if (!use_bus && st_reg.pend.valid && !st_reg.pend.write)
        begin
            st_next.scan_rsp = 1'b1;
            st_next.scan_data = rd;
        end
        // read side effect: host takes the word from the core
        if (acc.valid && !acc.write && acc.addr == cdec_pkg::REG_COMM_FROM)
        begin
            st_next.tx_full = 1'b0;
        end
        // core takes the host word; a same cycle host write still sets
        if (comms_read_i)
        begin
            st_next.rx_full = 1'b0;
        end
        // RL9 configuration writes
        if (acc.valid && acc.write)
        begin
            case (acc.addr)
                cdec_pkg::REG_CTRL:
                begin
                    st_next.monitor = acc.wdata[cdec_pkg::CTRL_MON_BIT];
                    resume_req = acc.wdata[cdec_pkg::CTRL_RESUME_BIT];
                end
                cdec_pkg::REG_STAT:
                begin
                    // write one to clear sticky hits
                    if (acc.wdata[cdec_pkg::STAT_BRK_BIT])
                        st_next.brk_hit = 1'b0;
                    if (acc.wdata[cdec_pkg::STAT_WPT_BIT])
                        st_next.wpt_hit = 1'b0;
                    if (acc.wdata[cdec_pkg::STAT_EXT_BIT])
                        st_next.ext_hit = 1'b0;
                end
                cdec_pkg::REG_DLY:
                    st_next.dly_req = acc.wdata[cdec_pkg::DLY_REQ_BIT];
                cdec_pkg::REG_INJ:
                begin
                    // RL10 inject into pipeline
                    if (st_reg.dbg == cdec_pkg::ST_HALT)
                    begin
                        st_next.inj_valid = 1'b1;
                        st_next.inj_instr = acc.wdata;
                    end
                end
                cdec_pkg::REG_COMM_TO:
                begin
                    st_next.to_core = acc.wdata;
                    st_next.rx_full = 1'b1;
                end
                default:
                begin
                    for (int i = 0; i < cdec_pkg::NUM_UNITS; i++)
                    begin
                        if (uidx == cdec_pkg::UNIT_IDX_BASE + 3'(i))
                        begin
                            case (uoff)
                                cdec_pkg::UNIT_AVAL:
                                    st_next.unit[i].addr_val = acc.wdata;
                                cdec_pkg::UNIT_AMSK:
                                    st_next.unit[i].addr_msk = acc.wdata;
                                cdec_pkg::UNIT_DVAL:
                                    st_next.unit[i].data_val = acc.wdata;
                                cdec_pkg::UNIT_DMSK:
                                    st_next.unit[i].data_msk = acc.wdata;
                                cdec_pkg::UNIT_CTL:
                                begin
                                    st_next.unit[i].ctrl_val =
                                        acc.wdata[cdec_pkg::UCTL_VAL_LSB +: 4];
                                    st_next.unit[i].ctrl_msk =
                                        acc.wdata[cdec_pkg::UCTL_MSK_LSB +: 4];
                                    st_next.unit[i].enable =
                                        acc.wdata[cdec_pkg::UCTL_EN_BIT];
                                    st_next.unit[i].kind =
                                        acc.wdata[cdec_pkg::UCTL_KIND_BIT];
                                end
                                default: st_next.unit[i].enable =
                                    st_reg.unit[i].enable;
                            endcase
                        end
                    end
                end
            endcase
        end
        // core posts a word, winning over a same cycle host read clear
        if (comms_write_i)
        begin
            st_next.from_core = comms_wdata_i;
            st_next.tx_full = 1'b1;
        end
        // RL2 monitor mode aborts
        st_next.pabort = in_run & st_reg.monitor & brk_any & ~req_any;
        st_next.dabort = in_run & st_reg.monitor & wpt_any & ~req_any;
        // sticky hits, set wins over the clear above
        if (in_run)
        begin
            st_next.brk_hit = st_next.brk_hit | brk_any;
            st_next.wpt_hit = st_next.wpt_hit | wpt_any;
            st_next.ext_hit = st_next.ext_hit | (|ext_gated);
        end
        // RL1 debug state sequence
        case (st_reg.dbg)
            cdec_pkg::ST_RUN:
            begin
                if (halt_evt)
                begin
                    st_next.dbg = cdec_pkg::ST_ENTER;
                    st_next.halt = 1'b1;
                    st_next.dly_req = 1'b0;
                end
            end
            cdec_pkg::ST_ENTER:
            begin
                if (core_stopped_i)
                    st_next.dbg = cdec_pkg::ST_HALT;
            end
            cdec_pkg::ST_HALT:
            begin
                if (resume_req)
                begin
                    st_next.dbg = cdec_pkg::ST_EXIT;
                    st_next.halt = 1'b0;
                end
            end
            cdec_pkg::ST_EXIT:
            begin
                if (!core_stopped_i)
                    st_next.dbg = cdec_pkg::ST_RUN;
            end
            default:
            begin
                st_next.dbg = cdec_pkg::ST_RUN;
                st_next.halt = 1'b0;
            end
        endcase
        // RL14 flag debug state
        // RL12 ack low when disabled
        st_next.ack = (st_next.dbg == cdec_pkg::ST_HALT) & en;
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign debug_state_ack_o = st_reg.ack;
    assign core_halt_o = st_reg.halt;
    assign prefetch_abort_o = st_reg.pabort;
    assign data_abort_o = st_reg.dabort;
    assign inject_valid_o = st_reg.inj_valid;
    assign inject_instr_o = st_reg.inj_instr;
    assign comms_rdata_o = st_reg.to_core;
    assign comms_rx_full_o = st_reg.rx_full;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // RL12 ack held low
    ack_low_off_a: assert property (!en |=> !debug_state_ack_o) // RL12
        else $error("ack high while debug disabled");
    // RL11 disabled pins never halt
    ext_blocked_a: assert property ( // RL11
        (in_run && !en && !(|unit_match) && !st_reg.dly_req)
        |=> !core_halt_o)
        else $error("blocked request halted the core");
    // RL1 halt on event
    halt_enter_a: assert property ( // RL1
        (in_run && halt_evt) |=> (core_halt_o
        && st_reg.dbg == cdec_pkg::ST_ENTER))
        else $error("event did not start debug entry");
    // RL1 resume releases core
    resume_exit_a: assert property ( // RL1
        (st_reg.dbg == cdec_pkg::ST_HALT && resume_req)
        |=> (!core_halt_o && st_reg.dbg == cdec_pkg::ST_EXIT))
        else $error("resume did not release the core");
    // RL2 breakpoint abort
    mon_pabort_a: assert property ( // RL2
        (in_run && st_reg.monitor && brk_any && !req_any)
        |=> (prefetch_abort_o && !core_halt_o))
        else $error("monitor breakpoint gave no prefetch abort");
    // RL2 watchpoint abort
    mon_dabort_a: assert property ( // RL2
        (in_run && st_reg.monitor && wpt_any && !req_any)
        |=> (data_abort_o && !core_halt_o))
        else $error("monitor watchpoint gave no data abort");
    // RL2 no aborts in halt mode
    halt_no_abort_a: assert property ( // RL2
        !st_reg.monitor |=> !(prefetch_abort_o || data_abort_o))
        else $error("abort raised outside monitor mode");
    // RL3 scanned request halts
    dly_req_a: assert property ( // RL3
        (in_run && st_reg.dly_req) |=> st_reg.dbg == cdec_pkg::ST_ENTER)
        else $error("scanned request ignored");
    // RL14 ack only in debug state
    ack_state_a: assert property ( // RL14
        debug_state_ack_o |-> (st_reg.dbg == cdec_pkg::ST_HALT && core_halt_o))
        else $error("ack outside debug state");
    // RL10 injection only in debug
    inject_halt_a: assert property ( // RL10
        inject_valid_o |-> $past(st_reg.dbg) == cdec_pkg::ST_HALT)
        else $error("injection outside debug state");
    // RL7 fully masked unit matches
    mask_all_a: assert property ( // RL7
        (st_reg.unit[0].enable && (&st_reg.unit[0].addr_msk)
        && (&st_reg.unit[0].data_msk) && (&st_reg.unit[0].ctrl_msk)
        && (st_reg.unit[0].kind ? fetch_i.valid : data_i.valid))
        |-> unit_match[0])
        else $error("masked comparator failed to match");

    halt_entry_c: cover property (in_run ##1 core_halt_o ##[1:20]
        debug_state_ack_o);
    mon_abort_c: cover property (prefetch_abort_o || data_abort_o);
    resume_c: cover property (st_reg.dbg == cdec_pkg::ST_EXIT ##1 in_run);
    inject_c: cover property (inject_valid_o);
endmodule

// File: cdec_pkg.sv
// cdec_pkg: constants, state codes and carrier types of the debug
// event control block.
// assumes a single core clock and byte addressed registers
package cdec_pkg;
    // register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DLY = 8'h08;
    localparam logic [7:0] REG_INJ = 8'h0C;
    localparam logic [7:0] REG_COMM_TO = 8'h10;
    localparam logic [7:0] REG_COMM_FROM = 8'h14;
    // comparator windows: unit index in addr[7:5], offset in addr[4:0]
    localparam int UNIT_IDX_LSB = 5;
    localparam logic [2:0] UNIT_IDX_BASE = 3'h1;
    localparam logic [4:0] UNIT_AVAL = 5'h00;
    localparam logic [4:0] UNIT_AMSK = 5'h04;
    localparam logic [4:0] UNIT_DVAL = 5'h08;
    localparam logic [4:0] UNIT_DMSK = 5'h0C;
    localparam logic [4:0] UNIT_CTL = 5'h10;
    // field positions
    localparam int CTRL_MON_BIT = 0;
    localparam int CTRL_RESUME_BIT = 1;
    localparam int DLY_REQ_BIT = 0;
    localparam int STAT_DEBUG_BIT = 0;
    localparam int STAT_BRK_BIT = 1;
    localparam int STAT_WPT_BIT = 2;
    localparam int STAT_EXT_BIT = 3;
    localparam int STAT_EN_BIT = 4;
    localparam int STAT_RXF_BIT = 5;
    localparam int STAT_TXF_BIT = 6;
    localparam int UCTL_VAL_LSB = 0;
    localparam int UCTL_MSK_LSB = 4;
    localparam int UCTL_EN_BIT = 8;
    localparam int UCTL_KIND_BIT = 9;
    // pin synchroniser lanes
    localparam int SYNC_BRK = 0;
    localparam int SYNC_WPT = 1;
    localparam int SYNC_REQ = 2;
    localparam int SYNC_EN = 3;
    localparam int SYNC_W = 4;
    // sizes and reset values
    localparam int NUM_UNITS = 2;
    localparam int CTRL_W = 4;
    localparam int SCAN_LEN = 41;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_ENTER = 2'h1,
        ST_HALT = 2'h3,
        ST_EXIT = 2'h2
    } cdec_dbg_state_type;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [CTRL_W-1:0] ctrl;
    } cdec_bus_type;

    typedef struct packed {
        logic enable;
        logic kind; // 1: instruction fetch breakpoint, 0: watchpoint
        logic [CTRL_W-1:0] ctrl_val;
        logic [CTRL_W-1:0] ctrl_msk;
        logic [31:0] addr_val;
        logic [31:0] addr_msk;
        logic [31:0] data_val;
        logic [31:0] data_msk;
    } cdec_unit_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } cdec_acc_type;
endpackage

// File: cdec_match_unit.sv
// cdec_match_unit: one masked comparator, breakpoint or watchpoint.
// assumes fetch and data samples are valid in the cycle they are shown
`timescale 1ns/1ps
module cdec_match_unit (
    input cdec_pkg::cdec_unit_type cfg_i,
    input cdec_pkg::cdec_bus_type fetch_i,
    input cdec_pkg::cdec_bus_type data_i,
    output logic match_o
);
    cdec_pkg::cdec_bus_type src;
    logic addr_ok;
    logic data_ok;
    logic ctrl_ok;

    // select the watched bus, then compare only the unmasked bits
    always_comb
    begin
        // RL5 fetch or data
        src = cfg_i.kind ? fetch_i : data_i;
        // RL7 masked bits ignored
        addr_ok = ((src.addr ^ cfg_i.addr_val) & ~cfg_i.addr_msk) == 32'h0;
        // RL8 data dependent match
        data_ok = ((src.data ^ cfg_i.data_val) & ~cfg_i.data_msk) == 32'h0;
        ctrl_ok = ((src.ctrl ^ cfg_i.ctrl_val) & ~cfg_i.ctrl_msk) == 4'h0;
        // RL6 all fields equal
        match_o = cfg_i.enable & src.valid & addr_ok & data_ok & ctrl_ok;
    end
endmodule

// File: cdec_scan_chain.sv
// cdec_scan_chain: serial access path from the debug host converter.
// assumes shift and update strobes are slow levels from pins, data held
// stable across each shift strobe rising edge
`timescale 1ns/1ps
module cdec_scan_chain (
    input logic ref_clk_i,
    input logic rstn_i,
    input logic scan_clk_i,
    input logic scan_din_i,
    input logic scan_update_i,
    input logic rsp_valid_i,
    input logic [31:0] rsp_data_i,
    output cdec_pkg::cdec_acc_type acc_o,
    output logic scan_dout_o
);
    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] prev;
        logic [cdec_pkg::SCAN_LEN-1:0] sr;
        cdec_pkg::cdec_acc_type acc;
    } cdec_scan_state_type;

    cdec_scan_state_type st_reg;
    cdec_scan_state_type st_next;

    // synchronise pins, shift on strobe edges, issue access on update
    always_comb
    begin
        st_next = st_reg;
        st_next.sync_a = {scan_update_i, scan_din_i, scan_clk_i};
        st_next.sync_b = st_reg.sync_a;
        st_next.prev = st_reg.sync_b;
        st_next.acc.valid = 1'b0;
        // RL9 serial programming
        if (st_reg.sync_b[0] && !st_reg.prev[0])
        begin
            st_next.sr = {st_reg.sr[cdec_pkg::SCAN_LEN-2:0], st_reg.sync_b[1]};
        end
        if (st_reg.sync_b[2] && !st_reg.prev[2])
        begin
            st_next.acc = {1'b1, st_reg.sr};
        end
        // read answer reloads the data field for shifting out
        if (rsp_valid_i)
        begin
            st_next.sr[31:0] = rsp_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign acc_o = st_reg.acc;
    assign scan_dout_o = st_reg.sr[cdec_pkg::SCAN_LEN-1];
endmodule

// File: cdec_host_model.sv
// cdec_host_model: debug host converter driving the scan pins.
// assumes ref_clk_i is the core clock; pins move after its edges
`timescale 1ns/1ps
module cdec_host_model (
    input wire logic ref_clk_i,
    output logic scan_clk_o,
    output logic scan_din_o,
    output logic scan_update_o
);
    task automatic scan_write(input logic [40:0] f);
        for (int i = 40; i >= 0; i--)
        begin
            scan_din_o <= f[i];
            repeat (3) @(posedge ref_clk_i);
            scan_clk_o <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            scan_clk_o <= 1'b0;
        end
        scan_din_o <= ~f[0]; // no stale level after the frame
        scan_update_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        scan_update_o <= 1'b0;
    endtask
    initial {scan_clk_o, scan_din_o, scan_update_o} = 3'h0;
endmodule

// File: testbench.sv
// testbench: drives pins, core buses and register port of the block.
// assumes the host model delivers scan frames
`timescale 1ns/1ps
module testbench;
    logic clk, rstn = 0, wr = 0, rd = 0, en = 0, req = 0, stop = 0;
    logic sc, sd, su, ack, halt, pab, dab, e, iv, crx;
    logic [7:0] addr = 8'h00, b;
    logic [31:0] wdata = 0, rdata, seed = 32'hCA04_9DEE, v, a, iin, cdat;
    cdec_pkg::cdec_bus_type fet = '0, dat = '0;
    int miscompares = 0, samples_checked = 0, cyc = 0, ninj = 0;
    cdec_host_model i_host (.ref_clk_i(clk), .scan_clk_o(sc),
        .scan_din_o(sd), .scan_update_o(su));
    cdec_event_ctrl i_dut (.ref_clk_i(clk), .rstn_i(rstn),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .scan_clk_i(sc),
        .scan_din_i(sd), .scan_update_i(su), .scan_dout_o(),
        .debug_global_enable_i(en), .ext_breakpoint_request_i(req),
        .ext_watchpoint_request_i(req), .ext_debug_request_i(req),
        .fetch_i(fet), .data_i(dat), .core_stopped_i(stop),
        .comms_read_i(1'b0), .comms_write_i(1'b0),
        .comms_wdata_i(32'h0000_0000), .debug_state_ack_o(ack),
        .core_halt_o(halt), .prefetch_abort_o(pab), .data_abort_o(dab),
        .inject_valid_o(iv), .inject_instr_o(iin), .comms_rdata_o(cdat),
        .comms_rx_full_o(crx));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
        wr <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk); // one idle edge between strobes
    endtask
    task automatic reg_rd(input logic [7:0] ad, input logic [31:0] exp);
        rd <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
        @(posedge clk);
    endtask
    // count injection strobes in the settled half of the cycle
    always @(negedge clk)
        if (rstn && iv !== 1'b0) ninj++;
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reg_rd(cdec_pkg::REG_STAT, 32'h0);
        // enable held low keeps debug off
        req <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check({halt, ack}, 0);
        @(posedge clk);
        en <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check(halt, 1);
        @(posedge clk);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(ack, 1);
        @(posedge clk);
        reg_rd(cdec_pkg::REG_STAT, 32'h1F);
        reg_wr(cdec_pkg::REG_INJ, 32'h5A5A_C3C3);
        check(iin, 32'h5A5A_C3C3);
        en <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(ack, 0);
        @(posedge clk);
        en <= 1'b1;
        req <= 1'b0;
        repeat (4) @(posedge clk);
        reg_wr(cdec_pkg::REG_CTRL, 32'h2);
        stop <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(halt, 0);
        @(posedge clk);
        reg_rd(8'hFC, 32'h0);
        reg_wr(cdec_pkg::REG_CTRL, 32'h1);
        for (int n = 0; n < 2; n++)
        begin
            b = n ? 8'h40 : 8'h20;
            v = rnd();
            reg_wr(b, v);
            reg_wr(b + 8'h04, 32'h0000_000F);
            reg_wr(b + 8'h0C, 32'hFFFF_FFFF);
            reg_wr(b + 8'h10, n ? 32'h0000_01F0 : 32'h0000_03F0);
            for (int k = 0; k < 8; k++)
            begin
                a = v ^ (rnd() & 32'h0000_001F);
                if (n == 0)
                    fet <= '{1'b1, a, rnd(), 4'h0};
                else
                    dat <= '{1'b1, a, rnd(), 4'h0};
                e = ((a ^ v) & 32'hFFFF_FFF0) == 0;
                @(posedge clk);
                fet.valid <= 1'b0;
                dat.valid <= 1'b0;
                #1 check(32'({pab, dab}), n ? 32'(e) : 32'({e, 1'b0}));
                @(posedge clk);
            end
        end
        #1 check(halt, 0);
        @(posedge clk);
        reg_wr(cdec_pkg::REG_INJ, 32'h0000_0000);
        check(iin, 32'h5A5A_C3C3);
        check(ninj, 1);
        reg_wr(cdec_pkg::REG_COMM_TO, v);
        check(crx, 1);
        check(cdat, v);
        reg_wr(cdec_pkg::REG_CTRL, 32'h0);
        i_host.scan_write({1'b1, cdec_pkg::REG_DLY, 32'h1});
        repeat (12) @(posedge clk);
        #1 check(halt, 1);
        final_report();
    end
endmodule
